/* design/emitter_receiver_pkg.sv */
// Constants and types for the register bank
// Summary of operation
// RULE_01: Current-off bit low enables 50 mA source
// RULE_02: First emitter current: 8-bit field, resets zero
// RULE_03: Second emitter current: low byte, resets zero
// RULE_04: Bridge bit: 0 H-bridge, 1 push-pull
// RULE_05: Crystal-disable selects crystal or external clock
// RULE_06: Three power-down bits: transmit, receive, whole
// RULE_07: Host writes only zeros to spare registers
// RULE_08: Factory registers return device-specific readback values
// RULE_09: Alarm clock enable: faults or monitored clocks
// RULE_10: Second emitter sample holds latest result
// RULE_11: Second emitter ambient holds latest result
// RULE_12: First emitter sample holds latest result
// RULE_13: Conversion-ready goes high on each update
// RULE_14: Host reads results before next conversion
// RULE_15: Clock-select picks alarm signals; 101+ none
// RULE_16: First emitter ambient holds latest result
// RULE_17: Host writes documented fixed ones, zeros elsewhere
// RULE_18: Result registers are read-only; writes ignored
package emitter_receiver_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 7;
    localparam int CURRENT_W = 8;

    // Register offsets
    localparam logic [6:0] OFS_EMITTER_DRIVE = 7'h22;
    localparam logic [6:0] OFS_POWER_CLOCK = 7'h23;
    localparam logic [6:0] OFS_SPARE_SECOND = 7'h24;
    localparam logic [6:0] OFS_SPARE_THIRD = 7'h25;
    localparam logic [6:0] OFS_SPARE_FOURTH = 7'h26;
    localparam logic [6:0] OFS_FACTORY_FIRST = 7'h27;
    localparam logic [6:0] OFS_FACTORY_SECOND = 7'h28;
    localparam logic [6:0] OFS_ALARM_PIN = 7'h29;
    localparam logic [6:0] OFS_SECOND_SAMPLE = 7'h2A;
    localparam logic [6:0] OFS_SECOND_AMBIENT = 7'h2B;
    localparam logic [6:0] OFS_FIRST_SAMPLE = 7'h2C;
    localparam logic [6:0] OFS_FIRST_AMBIENT = 7'h2D;

    // Field positions
    localparam int CURRENT_OFF_BIT = 17;
    localparam int FIRST_CURRENT_LSB = 8;
    localparam int SECOND_CURRENT_LSB = 0;
    localparam int BRIDGE_MODE_BIT = 11;
    localparam int CRYSTAL_DISABLE_BIT = 9;
    localparam int TX_PD_BIT = 2;
    localparam int RX_PD_BIT = 1;
    localparam int AFE_PD_BIT = 0;
    localparam int ALARM_CLK_EN_BIT = 7;

    // Reset values
    localparam logic [23:0] EMITTER_DRIVE_RESET = 24'h000000;
    localparam logic [23:0] POWER_CLOCK_RESET = 24'h000000;
    localparam logic [23:0] ALARM_PIN_RESET = 24'h000000;
    localparam logic [23:0] SAMPLE_RESET = 24'h000000;

    // Alarm select codes
    localparam logic [2:0] SEL_SAMPLE = 3'h0;
    localparam logic [2:0] SEL_PULSE = 3'h1;
    localparam logic [2:0] SEL_SAMPLE_PULSE = 3'h2;
    localparam logic [2:0] SEL_CONVERT = 3'h3;
    localparam logic [2:0] SEL_AMBIENT = 3'h4;

    // Frame: flag, 7 address, 24 data bits
    localparam logic [5:0] ADDR_LAST_BIT = 6'h07;
    localparam logic [5:0] FRAME_LAST_BIT = 6'h1F;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_ADDR = 2'b01,
        SPI_DATA = 2'b11,
        SPI_DONE = 2'b10
    } spi_state_e;
endpackage : emitter_receiver_pkg

/* design/sample_capture.sv */
// Converter result holding registers
`timescale 1ns/1ns
module sample_capture #(
    parameter int WIDTH = emitter_receiver_pkg::DATA_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Converter results
    input wire logic conv_valid,
    input wire logic [WIDTH-1:0] conv_second_sample,
    input wire logic [WIDTH-1:0] conv_second_ambient,
    input wire logic [WIDTH-1:0] conv_first_sample,
    input wire logic [WIDTH-1:0] conv_first_ambient,
    // Held results
    output logic [WIDTH-1:0] second_emitter_sample,
    output logic [WIDTH-1:0] second_emitter_ambient_sample,
    output logic [WIDTH-1:0] first_emitter_sample,
    output logic [WIDTH-1:0] first_emitter_ambient_sample,
    output logic conv_ready
);
    import emitter_receiver_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] second_smp;
        logic [WIDTH-1:0] second_amb;
        logic [WIDTH-1:0] first_smp;
        logic [WIDTH-1:0] first_amb;
        logic ready;
    } capture_s;

    capture_s state_reg;
    capture_s state_next;

    // New results replace old ones whether read or not
    always_comb begin
        state_next = state_reg;
        state_next.ready = 1'b0;
        if (conv_valid) begin
            state_next.second_smp = conv_second_sample; // RULE_10 RULE_14
            state_next.second_amb = conv_second_ambient; // RULE_11
            state_next.first_smp = conv_first_sample; // RULE_12
            state_next.first_amb = conv_first_ambient; // RULE_16
            state_next.ready = 1'b1; // RULE_13
        end
    end

    // Clock enable low holds everything
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= '{SAMPLE_RESET[WIDTH-1:0], SAMPLE_RESET[WIDTH-1:0],
                           SAMPLE_RESET[WIDTH-1:0], SAMPLE_RESET[WIDTH-1:0], 1'b0};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign second_emitter_sample = state_reg.second_smp;
    assign second_emitter_ambient_sample = state_reg.second_amb;
    assign first_emitter_sample = state_reg.first_smp;
    assign first_emitter_ambient_sample = state_reg.first_amb;
    assign conv_ready = state_reg.ready;
endmodule : sample_capture

/* design/alarm_pin_mux.sv */
// Alarm pin source: faults or monitored clocks
`timescale 1ns/1ns
module alarm_pin_mux (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic clock_monitor_enable,
    input wire logic [2:0] clock_select,
    // Diagnostic faults
    input wire logic photodiode_fault,
    input wire logic emitter_fault,
    // Internal phase strobes
    input wire logic second_sample_phase,
    input wire logic first_sample_phase,
    input wire logic second_pulse_phase,
    input wire logic first_pulse_phase,
    input wire logic second_convert_phase,
    input wire logic first_convert_phase,
    input wire logic second_ambient_phase,
    input wire logic first_ambient_phase,
    // Pins
    output logic photodiode_alarm_pin,
    output logic emitter_alarm_pin
);
    import emitter_receiver_pkg::*;

    typedef struct packed {
        logic pd_pin;
        logic em_pin;
    } alarm_s;

    alarm_s state_reg;
    alarm_s state_next;

    // Registered so select changes cannot glitch pins
    always_comb begin
        state_next = state_reg;
        if (!clock_monitor_enable) begin
            state_next.pd_pin = photodiode_fault; // RULE_09
            state_next.em_pin = emitter_fault;
        end else begin
            case (clock_select) // RULE_15
                SEL_SAMPLE: begin
                    state_next.pd_pin = second_sample_phase;
                    state_next.em_pin = first_sample_phase;
                end
                SEL_PULSE: begin
                    state_next.pd_pin = second_pulse_phase;
                    state_next.em_pin = first_pulse_phase;
                end
                SEL_SAMPLE_PULSE: begin
                    state_next.pd_pin = second_sample_phase;
                    state_next.em_pin = first_pulse_phase;
                end
                SEL_CONVERT: begin
                    state_next.pd_pin = second_convert_phase;
                    state_next.em_pin = first_convert_phase;
                end
                SEL_AMBIENT: begin
                    state_next.pd_pin = second_ambient_phase;
                    state_next.em_pin = first_ambient_phase;
                end
                default: begin
                    state_next.pd_pin = 1'b0;
                    state_next.em_pin = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    assign photodiode_alarm_pin = state_reg.pd_pin;
    assign emitter_alarm_pin = state_reg.em_pin;
endmodule : alarm_pin_mux

/* design/emitter_receiver_register_bank.sv */
// Serial register bank: drive, power, clock, results
`timescale 1ns/1ns
module emitter_receiver_register_bank #(
    // Factory readback contents; values are arbitrary
    parameter logic [23:0] FACTORY_FIRST_VALUE = 24'h00A5C3,
    parameter logic [23:0] FACTORY_SECOND_VALUE = 24'h003C5A
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Serial port pins
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Converter results
    input wire logic conv_valid,
    input wire logic [emitter_receiver_pkg::DATA_W-1:0] conv_second_sample,
    input wire logic [emitter_receiver_pkg::DATA_W-1:0] conv_second_ambient,
    input wire logic [emitter_receiver_pkg::DATA_W-1:0] conv_first_sample,
    input wire logic [emitter_receiver_pkg::DATA_W-1:0] conv_first_ambient,
    output logic conv_ready,
    // Alarm sources and select
    input wire logic [2:0] alarm_clock_select,
    input wire logic photodiode_fault,
    input wire logic emitter_fault,
    input wire logic second_sample_phase,
    input wire logic first_sample_phase,
    input wire logic second_pulse_phase,
    input wire logic first_pulse_phase,
    input wire logic second_convert_phase,
    input wire logic first_convert_phase,
    input wire logic second_ambient_phase,
    input wire logic first_ambient_phase,
    output logic photodiode_alarm_pin,
    output logic emitter_alarm_pin,
    // Emitter drive controls
    output logic emitter_current_off,
    output logic current_source_enable,
    output logic [emitter_receiver_pkg::CURRENT_W-1:0] first_emitter_current,
    output logic [emitter_receiver_pkg::CURRENT_W-1:0] second_emitter_current,
    output logic driver_bridge_mode,
    // Clock source controls
    output logic crystal_disable,
    output logic oscillator_enable,
    // Power controls
    output logic transmit_power_down,
    output logic receive_power_down,
    output logic front_end_power_down,
    output logic transmitter_enable,
    output logic receiver_enable,
    output logic diagnostics_enable
);
    import emitter_receiver_pkg::*;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] mosi_s;
        logic [1:0] sel_s;
        spi_state_e state;
        logic [5:0] bit_cnt;
        logic [31:0] shift_in;
        logic [23:0] shift_out;
        logic rd;
        logic [6:0] addr;
        logic miso;
        logic miso_oe;
        logic [23:0] drive_word;
        logic [23:0] power_word;
        logic [23:0] alarm_word;
        logic src_en;
        logic osc_en;
        logic tx_en;
        logic rx_en;
        logic diag_en;
    } bank_s;

    bank_s state_reg;
    bank_s state_next;

    logic [23:0] second_smp;
    logic [23:0] second_amb;
    logic [23:0] first_smp;
    logic [23:0] first_amb;
    logic [6:0] rd_addr;
    logic [23:0] rd_word;
    logic rise;
    logic fall;

    // Result holding registers
    sample_capture #(
        .WIDTH(DATA_W)
    ) u_capture (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .conv_valid(conv_valid),
        .conv_second_sample(conv_second_sample),
        .conv_second_ambient(conv_second_ambient),
        .conv_first_sample(conv_first_sample),
        .conv_first_ambient(conv_first_ambient),
        .second_emitter_sample(second_smp),
        .second_emitter_ambient_sample(second_amb),
        .first_emitter_sample(first_smp),
        .first_emitter_ambient_sample(first_amb),
        .conv_ready(conv_ready)
    );

    // Alarm pin routing
    alarm_pin_mux u_alarm (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .clock_monitor_enable(state_reg.alarm_word[ALARM_CLK_EN_BIT]),
        .clock_select(alarm_clock_select),
        .photodiode_fault(photodiode_fault),
        .emitter_fault(emitter_fault),
        .second_sample_phase(second_sample_phase),
        .first_sample_phase(first_sample_phase),
        .second_pulse_phase(second_pulse_phase),
        .first_pulse_phase(first_pulse_phase),
        .second_convert_phase(second_convert_phase),
        .first_convert_phase(first_convert_phase),
        .second_ambient_phase(second_ambient_phase),
        .first_ambient_phase(first_ambient_phase),
        .photodiode_alarm_pin(photodiode_alarm_pin),
        .emitter_alarm_pin(emitter_alarm_pin)
    );

    // Edges seen on the synchronised serial clock only
    assign rise = state_reg.sclk_s[1] & ~state_reg.sclk_s[2];
    assign fall = ~state_reg.sclk_s[1] & state_reg.sclk_s[2];
    assign rd_addr = {state_reg.shift_in[5:0], state_reg.mosi_s[1]};

    // Read decode; spares and unmapped offsets read as zero
    always_comb begin
        if (rd_addr == OFS_EMITTER_DRIVE) begin
            rd_word = state_reg.drive_word;
        end else if (rd_addr == OFS_POWER_CLOCK) begin
            rd_word = state_reg.power_word;
        end else if (rd_addr == OFS_FACTORY_FIRST) begin
            rd_word = FACTORY_FIRST_VALUE; // RULE_08
        end else if (rd_addr == OFS_FACTORY_SECOND) begin
            rd_word = FACTORY_SECOND_VALUE; // RULE_08
        end else if (rd_addr == OFS_ALARM_PIN) begin
            rd_word = state_reg.alarm_word;
        end else if (rd_addr == OFS_SECOND_SAMPLE) begin
            rd_word = second_smp; // RULE_10
        end else if (rd_addr == OFS_SECOND_AMBIENT) begin
            rd_word = second_amb; // RULE_11
        end else if (rd_addr == OFS_FIRST_SAMPLE) begin
            rd_word = first_smp; // RULE_12
        end else if (rd_addr == OFS_FIRST_AMBIENT) begin
            rd_word = first_amb; // RULE_16
        end else begin
            rd_word = 24'h000000;
        end
    end

    // Serial slave, register writes and derived controls
    always_comb begin
        logic wr_en;
        logic [23:0] wr_data;
        wr_en = 1'b0;
        wr_data = {state_reg.shift_in[22:0], state_reg.mosi_s[1]};
        state_next = state_reg;
        // Two-stage pin synchronisers
        state_next.sclk_s = {state_reg.sclk_s[1:0], spi_clk};
        state_next.mosi_s = {state_reg.mosi_s[0], spi_mosi};
        state_next.sel_s = {state_reg.sel_s[0], ~spi_cs_n};
        if (!state_reg.sel_s[1]) begin
            // Deselect aborts any frame; a partial write is dropped
            state_next.state = SPI_IDLE;
            state_next.bit_cnt = 6'h00;
            state_next.miso = 1'b0;
            state_next.miso_oe = 1'b0;
        end else begin
            case (state_reg.state)
                SPI_IDLE: begin
                    state_next.state = SPI_ADDR;
                    state_next.miso_oe = 1'b1;
                end
                SPI_ADDR: begin
                    if (rise) begin
                        state_next.shift_in = {state_reg.shift_in[30:0], state_reg.mosi_s[1]};
                        state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
                        if (state_reg.bit_cnt == ADDR_LAST_BIT) begin
                            state_next.rd = state_reg.shift_in[6];
                            state_next.addr = rd_addr;
                            state_next.shift_out = rd_word;
                            state_next.state = SPI_DATA;
                        end
                    end
                end
                SPI_DATA: begin
                    // Shift out on fall; host samples on rise
                    if (fall && state_reg.rd) begin
                        state_next.miso = state_reg.shift_out[23];
                        state_next.shift_out = {state_reg.shift_out[22:0], 1'b0};
                    end
                    if (rise) begin
                        state_next.shift_in = {state_reg.shift_in[30:0], state_reg.mosi_s[1]};
                        state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
                        if (state_reg.bit_cnt == FRAME_LAST_BIT) begin
                            wr_en = ~state_reg.rd;
                            state_next.state = SPI_DONE;
                        end
                    end
                end
                SPI_DONE: begin
                    // Extra clocks in the same frame are ignored
                    state_next.state = SPI_DONE;
                end
                default: begin
                    state_next.state = SPI_IDLE;
                end
            endcase
        end
        // Only control words take writes
        if (wr_en) begin
            if (state_reg.addr == OFS_EMITTER_DRIVE) begin
                state_next.drive_word = wr_data; // RULE_02 RULE_03
            end else if (state_reg.addr == OFS_POWER_CLOCK) begin
                state_next.power_word = wr_data;
            end else if (state_reg.addr == OFS_ALARM_PIN) begin
                state_next.alarm_word = wr_data; // RULE_09
            end else begin
                state_next.drive_word = state_reg.drive_word; // RULE_18
            end
        end
        // Whole front end power-down overrides the section bits
        state_next.src_en = ~state_next.drive_word[CURRENT_OFF_BIT] // RULE_01
            & ~state_next.power_word[TX_PD_BIT] & ~state_next.power_word[AFE_PD_BIT];
        state_next.osc_en = ~state_next.power_word[CRYSTAL_DISABLE_BIT]; // RULE_05
        state_next.tx_en = ~state_next.power_word[TX_PD_BIT] // RULE_06
            & ~state_next.power_word[AFE_PD_BIT];
        state_next.rx_en = ~state_next.power_word[RX_PD_BIT] // RULE_06
            & ~state_next.power_word[AFE_PD_BIT];
        state_next.diag_en = ~state_next.power_word[AFE_PD_BIT]; // RULE_06
    end

    // Clock enable low freezes the bank
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.drive_word <= EMITTER_DRIVE_RESET;
            state_reg.power_word <= POWER_CLOCK_RESET;
            state_reg.alarm_word <= ALARM_PIN_RESET;
            state_reg.src_en <= 1'b1;
            state_reg.osc_en <= 1'b1;
            state_reg.tx_en <= 1'b1;
            state_reg.rx_en <= 1'b1;
            state_reg.diag_en <= 1'b1;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Outputs from register bits
    assign spi_miso = state_reg.miso;
    assign spi_miso_oe = state_reg.miso_oe;
    assign emitter_current_off = state_reg.drive_word[CURRENT_OFF_BIT]; // RULE_01
    assign current_source_enable = state_reg.src_en;
    assign first_emitter_current =
        state_reg.drive_word[FIRST_CURRENT_LSB +: CURRENT_W]; // RULE_02
    assign second_emitter_current =
        state_reg.drive_word[SECOND_CURRENT_LSB +: CURRENT_W]; // RULE_03
    assign driver_bridge_mode = state_reg.power_word[BRIDGE_MODE_BIT]; // RULE_04
    assign crystal_disable = state_reg.power_word[CRYSTAL_DISABLE_BIT]; // RULE_05
    assign oscillator_enable = state_reg.osc_en;
    assign transmit_power_down = state_reg.power_word[TX_PD_BIT]; // RULE_06
    assign receive_power_down = state_reg.power_word[RX_PD_BIT];
    assign front_end_power_down = state_reg.power_word[AFE_PD_BIT];
    assign transmitter_enable = state_reg.tx_en;
    assign receiver_enable = state_reg.rx_en;
    assign diagnostics_enable = state_reg.diag_en;
endmodule : emitter_receiver_register_bank

/* dv/emitter_receiver_register_bank_checker.sv */
// Port assertions for the register bank
`timescale 1ns/1ns
module emitter_receiver_register_bank_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Converter and alarm
    input wire logic conv_valid,
    input wire logic conv_ready,
    input wire logic [2:0] alarm_clock_select,
    input wire logic photodiode_fault,
    input wire logic photodiode_alarm_pin,
    // Drive, clock and power
    input wire logic emitter_current_off,
    input wire logic current_source_enable,
    input wire logic crystal_disable,
    input wire logic oscillator_enable,
    input wire logic transmit_power_down,
    input wire logic receive_power_down,
    input wire logic front_end_power_down,
    input wire logic transmitter_enable,
    input wire logic receiver_enable,
    input wire logic diagnostics_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Ready strobes once per result set
    chk_ready_follows: assert property (conv_valid |=> conv_ready)
        else $error("ready missing");
    chk_ready_cause: assert property (!conv_valid |=> !conv_ready)
        else $error("ready without data");
    // Enables follow the stored bits
    chk_source_gate: assert property (current_source_enable ==
        !(emitter_current_off || transmit_power_down || front_end_power_down))
        else $error("source enable wrong");
    chk_tx_gate: assert property (transmitter_enable ==
        !(transmit_power_down || front_end_power_down)) else $error("tx enable wrong");
    chk_rx_gate: assert property (receiver_enable ==
        !(receive_power_down || front_end_power_down)) else $error("rx enable wrong");
    chk_diag_gate: assert property (diagnostics_enable == !front_end_power_down)
        else $error("diag enable wrong");
    chk_osc_gate: assert property (oscillator_enable == !crystal_disable)
        else $error("oscillator wrong");
    // Codes above 4 and no fault: pin low
    chk_alarm_quiet: assert property ($past(alarm_clock_select) > 3'h4
        && !$past(photodiode_fault) |-> !photodiode_alarm_pin) else $error("alarm not quiet");
    cov_ready: cover property (conv_ready);
    cov_tx_off: cover property (transmit_power_down && receiver_enable);
    cov_alarm: cover property (photodiode_alarm_pin);
endmodule : emitter_receiver_register_bank_checker

bind emitter_receiver_register_bank emitter_receiver_register_bank_checker i_chk (.*);

/* dv/spi_host_model.sv */
// Serial host model, mode 0
`timescale 1ns/1ns
module spi_host_model (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // Phases outlast the pin synchroniser
    task automatic half();
        repeat (6) @(posedge mclk);
    endtask : half
    // Flag, address, 24 data bits, MSB first
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [23:0] wd,
        output logic [23:0] rdat);
        logic [31:0] w;
        w = {rd, a, wd};
        rdat = 24'h000000;
        spi_cs_n <= 1'b0;
        half();
        for (int i = 31; i >= 0; i--) begin
            spi_mosi <= w[i];
            half();
            spi_clk <= 1'b1;
            rdat = {rdat[22:0], spi_miso};
            half();
            spi_clk <= 1'b0;
        end
        half();
        spi_cs_n <= 1'b1;
        spi_mosi <= ~w[0]; // Released line shows no stale bit
        half();
    endtask : xfer
endmodule : spi_host_model

/* dv/emitter_receiver_register_bank_tb.sv */
// Bench for the register bank
`timescale 1ns/1ns
module emitter_receiver_register_bank_tb;
    import emitter_receiver_pkg::*;
    localparam logic [23:0] FAC1 = 24'h00A5C3;
    localparam logic [23:0] FAC2 = 24'h003C5A;
    logic mclk, spi_clk, spi_cs_n, spi_mosi, spi_miso, conv_ready, photodiode_alarm_pin;
    logic rstn = 1'b0, conv_valid = 1'b0, photodiode_fault = 1'b0, emitter_fault = 1'b0;
    logic [2:0] alarm_clock_select = 3'h0;
    logic [7:0] phase = 8'h00;
    logic [23:0] conv_second_sample = 24'h0, conv_second_ambient = 24'h0;
    logic [23:0] conv_first_sample = 24'h0, conv_first_ambient = 24'h0;
    logic [7:0] first_emitter_current, second_emitter_current;
    logic emitter_alarm_pin, emitter_current_off, current_source_enable, driver_bridge_mode;
    logic crystal_disable, oscillator_enable, transmit_power_down, receive_power_down;
    logic front_end_power_down, transmitter_enable, receiver_enable, diagnostics_enable;
    logic [23:0] q[$], seen, rd, v;
    int n_mismatch, n_checks, cyc;
    event rd_done;
    emitter_receiver_register_bank #(.FACTORY_FIRST_VALUE(FAC1),
        .FACTORY_SECOND_VALUE(FAC2)) i_dut (.*, .ce(1'b1), .spi_miso_oe(),
        .second_sample_phase(phase[0]), .first_sample_phase(phase[1]),
        .second_pulse_phase(phase[2]), .first_pulse_phase(phase[3]),
        .second_convert_phase(phase[4]), .first_convert_phase(phase[5]),
        .second_ambient_phase(phase[6]), .first_ambient_phase(phase[7]));
    spi_host_model i_host (.*);
    task automatic check(input logic [23:0] got_v, input logic [23:0] exp_v);
        n_checks++;
        if (got_v !== exp_v) begin
            n_mismatch++;
            $display("mismatch %0t: %h exp %h", $time, got_v, exp_v);
        end
    endtask : check
    // Reads queue the expected word
    task automatic rd_reg(input logic [6:0] a, input logic [23:0] e);
        q.push_back(e);
        i_host.xfer(1'b1, a, 24'h000000, seen);
        ->rd_done;
    endtask : rd_reg
    task automatic wr_reg(input logic [6:0] a, input logic [23:0] d);
        i_host.xfer(1'b0, a, d, rd);
    endtask : wr_reg
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    // Oldest note per returned word
    always @(rd_done) check(seen, q.pop_front());
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        logic [23:0] e;
        void'($urandom(32'h7077212A));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        check(24'({transmitter_enable, receiver_enable, diagnostics_enable}), 24'h7);
        for (int a = 36; a < 39; a++) wr_reg(7'(a), 24'h000000);
        // Reset, factory and unmapped reads
        for (int i = 0; i < 13; i++) begin
            e = (i == 5) ? FAC1 : (i == 6) ? FAC2 : 24'h000000;
            rd_reg((i == 12) ? 7'h40 : 7'h22 + 7'(i), e);
        end
        repeat (3) begin
            v = {6'h00, 1'($urandom), 1'b1, 16'($urandom)};
            wr_reg(OFS_EMITTER_DRIVE, v);
            check(24'(emitter_current_off), 24'(v[17]));
            check(24'(first_emitter_current), 24'(v[15:8]));
            check(24'(second_emitter_current), 24'(v[7:0]));
            rd_reg(OFS_EMITTER_DRIVE, v);
        end
        repeat (4) begin
            v = 24'h020100 | (24'($urandom) & 24'h000A07);
            wr_reg(OFS_POWER_CLOCK, v);
            check(24'({driver_bridge_mode, crystal_disable}), 24'({v[11], v[9]}));
            check(24'({transmit_power_down, receive_power_down, front_end_power_down}),
                24'(v[2:0]));
            rd_reg(OFS_POWER_CLOCK, v);
        end
        // Fault outputs first, then every monitored code
        for (int i = 3; i >= 0; i--) begin
            {photodiode_fault, emitter_fault} <= 2'(i);
            repeat (3) @(posedge mclk);
            check(24'({photodiode_alarm_pin, emitter_alarm_pin}), 24'(i));
        end
        wr_reg(OFS_ALARM_PIN, 24'h000080);
        for (int c = 0; c < 8; c++) begin
            alarm_clock_select <= 3'(c);
            phase <= 8'($urandom);
            repeat (3) @(posedge mclk);
            e = (c > 4) ? 24'h0 : 24'({phase[(c == 2) ? 0 : 2*c-2*(c>2)],
                phase[(c == 2) ? 3 : 2*c+1-2*(c>2)]});
            check(24'({photodiode_alarm_pin, emitter_alarm_pin}), e);
        end
        // Only the later result set is held
        repeat (2) begin
            conv_valid <= 1'b1;
            {conv_second_sample, conv_second_ambient, conv_first_sample, conv_first_ambient}
                <= {$urandom, $urandom, $urandom};
            @(posedge mclk);
        end
        conv_valid <= 1'b0;
        rd_reg(OFS_SECOND_SAMPLE, conv_second_sample);
        rd_reg(OFS_SECOND_AMBIENT, conv_second_ambient);
        rd_reg(OFS_FIRST_SAMPLE, conv_first_sample);
        rd_reg(OFS_FIRST_AMBIENT, conv_first_ambient);
        wr_reg(OFS_FIRST_SAMPLE, ~conv_first_sample);
        rd_reg(OFS_FIRST_SAMPLE, conv_first_sample);
        @(posedge mclk);
        finish_test();
    end
endmodule : emitter_receiver_register_bank_tb
